// ==== rtl/imrc_pkg.sv ====
// constants and carrier types for the two-wire mux route control block
// assumes the slave samples the serial bus with a much faster ref_clk
package imrc_pkg;

  // width of the one control byte
  localparam int unsigned IMRC_CTRL_W = 8;

  // bits in one serial byte, and the counter width that reaches it
  localparam int unsigned IMRC_CNT_W = 4;
  localparam logic [3:0] IMRC_BYTE_BITS = 4'h8;
  localparam logic [3:0] IMRC_CNT_ZERO = 4'h0;
  localparam logic [3:0] IMRC_CNT_ONE = 4'h1;

  // fixed upper five bits of the slave address byte
  localparam logic [4:0] IMRC_ADDR_PREFIX = 5'h1b;

  // read/write flag value that marks a write
  localparam logic IMRC_RW_WRITE = 1'h0;

  // number of switch banks
  localparam int unsigned IMRC_BANKS = 4;

  // control byte layout, bit 7 down to bit 0
  typedef struct packed {
    logic bank_g_routing_kind;     // bit 7
    logic bank_g_single_out_pick;  // bit 6
    logic bank_e_routing_kind;     // bit 5
    logic bank_e_single_out_pick;  // bit 4
    logic bank_c_routing_kind;     // bit 3
    logic bank_c_single_out_pick;  // bit 2
    logic bank_a_routing_kind;     // bit 1
    logic bank_a_single_out_pick;  // bit 0
  } imrc_ctrl_t;

  // power-up value: all kinds one, all picks zero
  localparam imrc_ctrl_t IMRC_CTRL_RESET = 8'haa;

  // routing kind encodings
  localparam logic IMRC_KIND_STRAIGHT = 1'h0;
  localparam logic IMRC_KIND_MUX = 1'h1;

  // inputs of one bank
  typedef struct packed {
    logic in_zero;
    logic in_one;
    logic fanout_in;
  } imrc_bank_in_t;

  // outputs of one bank; single_oe low means high-impedance
  typedef struct packed {
    logic single_out;
    logic single_oe;
    logic pair_out_zero;
    logic pair_out_one;
  } imrc_bank_out_t;

  // serial slave states, one-hot
  typedef enum logic [5:0] {
    IMRC_IDLE = 6'h01,
    IMRC_ADDR = 6'h02,
    IMRC_AACK = 6'h04,
    IMRC_DATA = 6'h08,
    IMRC_DACK = 6'h10,
    IMRC_SKIP = 6'h20
  } imrc_state_t;

endpackage

// ==== rtl/imrc_top.sv ====
// two-wire serial slave that loads one control byte and routes four banks
// assumes ref_clk runs far faster than the serial clock; scl, sda and the
// address pins are asynchronous and are synchronised before use
//
// What this block does
// - four banks, two control bits each
// - byte bits: kind/pick for g,e,c,a banks
// - power-up: kinds one, picks zero
// - bank a pick zero: single follows input zero
// - bank a pick one: single follows input one
// - kind zero: single off, pairs swap inputs
// - bank c routes like bank a
// - bank e routes like bank a
// - bank g routes like bank a
// - four addresses chosen by two pins
// - address 11011, pin high, pin low, rw
// - sample data on serial clock rising edge
// - slave only: start, data, ack, stop
// - one data byte; later bytes not acked
// - byte takes effect only at stop
`timescale 1ns/1ps
`default_nettype none

module imrc_top
  import imrc_pkg::*;
(
  input wire logic ref_clk,                // block clock, 10 MHz
  input wire logic resetn,                 // synchronous reset, low
  input wire logic scl_pin,                // serial clock from master
  input wire logic sda_pin_in,             // serial data wire level
  output logic sda_pin_out,                // data drive value
  output logic sda_pin_oe,                 // high while pulling low
  input wire logic slave_addr_pin_low,     // address select, bit 1
  input wire logic slave_addr_pin_high,    // address select, bit 2
  input wire logic bank_a_in_zero,         // bank a input zero
  input wire logic bank_a_in_one,          // bank a input one
  input wire logic bank_a_fanout_in,       // bank a fan-out input
  input wire logic bank_c_in_zero,         // bank c input zero
  input wire logic bank_c_in_one,          // bank c input one
  input wire logic bank_c_fanout_in,       // bank c fan-out input
  input wire logic bank_e_in_zero,         // bank e input zero
  input wire logic bank_e_in_one,          // bank e input one
  input wire logic bank_e_fanout_in,       // bank e fan-out input
  input wire logic bank_g_in_zero,         // bank g input zero
  input wire logic bank_g_in_one,          // bank g input one
  input wire logic bank_g_fanout_in,       // bank g fan-out input
  output logic bank_a_single_out,          // bank a single output
  output logic bank_a_single_out_oe,       // low: single is high-z
  output logic bank_a_pair_out_zero,       // bank a pair output zero
  output logic bank_a_pair_out_one,        // bank a pair output one
  output logic bank_c_single_out,          // bank c single output
  output logic bank_c_single_out_oe,       // low: single is high-z
  output logic bank_c_pair_out_zero,       // bank c pair output zero
  output logic bank_c_pair_out_one,        // bank c pair output one
  output logic bank_e_single_out,          // bank e single output
  output logic bank_e_single_out_oe,       // low: single is high-z
  output logic bank_e_pair_out_zero,       // bank e pair output zero
  output logic bank_e_pair_out_one,        // bank e pair output one
  output logic bank_g_single_out,          // bank g single output
  output logic bank_g_single_out_oe,       // low: single is high-z
  output logic bank_g_pair_out_zero,       // bank g pair output zero
  output logic bank_g_pair_out_one,        // bank g pair output one
  output imrc_ctrl_t route_ctrl            // latched control byte
);

  // one bank's routing from its inputs and its two control bits
  function automatic imrc_bank_out_t imrc_route(
    input imrc_bank_in_t bin,
    input logic kind,
    input logic pick
  );
    imrc_bank_out_t bout;
    // kind outranks pick, so pick is a don't-care in straight routing
    if (kind == IMRC_KIND_MUX) begin
      // two-to-one onto single, fan-out to both pairs
      bout.single_out = pick ? bin.in_one : bin.in_zero;
      bout.single_oe = 1'h1;
      bout.pair_out_zero = bin.fanout_in;
      bout.pair_out_one = bin.fanout_in;
    end else begin
      // single floats, pairs take the inputs crossed over
      bout.single_out = 1'h0;
      bout.single_oe = 1'h0;
      bout.pair_out_zero = bin.in_one;
      bout.pair_out_one = bin.in_zero;
    end
    return bout;
  endfunction

  // synchroniser stages; stage one feeds only stage two
  logic scl_s1, scl_s2;             // serial clock stages
  logic sda_s1, sda_s2;             // serial data stages
  logic [1:0] adr_s1, adr_s2;       // address pin stages
  logic scl_d, sda_d;               // previous settled samples

  // two flops per asynchronous input, then one delay for edges
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      scl_s1 <= 1'h1;
      scl_s2 <= 1'h1;
      sda_s1 <= 1'h1;
      sda_s2 <= 1'h1;
      adr_s1 <= 2'h0;
      adr_s2 <= 2'h0;
      scl_d <= 1'h1;
      sda_d <= 1'h1;
    end else begin
      scl_s1 <= scl_pin;
      scl_s2 <= scl_s1;
      sda_s1 <= sda_pin_in;
      sda_s2 <= sda_s1;
      adr_s1 <= {slave_addr_pin_high, slave_addr_pin_low};
      adr_s2 <= adr_s1;
      scl_d <= scl_s2;
      sda_d <= sda_s2;
    end
  end

  // bus events seen on the settled samples; both lines pass the same two
  // stages, so their order on the pins is kept and a data change in the
  // clock-low phase can never pass for a start or a stop
  logic scl_rise, scl_fall;         // serial clock edges
  logic start_seen, stop_seen;      // bus conditions

  // data moving while the clock is high marks start or stop
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign start_seen = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign stop_seen = scl_s2 & scl_d & ~sda_d & sda_s2;

  // expected address byte without its rw flag
  logic [6:0] own_addr;
  assign own_addr = {IMRC_ADDR_PREFIX, adr_s2};

  // slave state and its next values; the count is cleared only by a start
  // or by the address ack, and the skip state never counts, so a long run
  // of extra bytes cannot wrap round into a load
  imrc_state_t state, next_state;
  logic [IMRC_CNT_W-1:0] cnt, next_cnt;     // bits taken this byte
  logic [IMRC_CTRL_W-1:0] shift, next_shift; // incoming byte
  logic [IMRC_CTRL_W-1:0] held, next_held;   // byte awaiting stop
  logic held_ok, next_held_ok;              // a full byte is held
  imrc_ctrl_t ctrl, next_ctrl;              // live control byte
  logic ack_oe, next_ack_oe;                // pulling data low

  // next-state logic for the serial slave
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_shift = shift;
    next_held = held;
    next_held_ok = held_ok;
    next_ctrl = ctrl;
    next_ack_oe = ack_oe;
    if (stop_seen) begin
      // a byte counts only once the master has stopped
      if (held_ok) begin
        next_ctrl = imrc_ctrl_t'(held);
      end
      next_held_ok = 1'h0;
      next_ack_oe = 1'h0;
      next_state = IMRC_IDLE;
    end else if (start_seen) begin
      // a start, repeated or not, always begins a new address
      next_cnt = IMRC_CNT_ZERO;
      next_held_ok = 1'h0;
      next_ack_oe = 1'h0;
      next_state = IMRC_ADDR;
    end else begin
      case (state)
        IMRC_IDLE: begin
          // nothing to do until a start
          next_ack_oe = 1'h0;
        end
        IMRC_ADDR: begin
          if (scl_rise) begin
            // shift on the rising clock edge
            next_shift = {shift[6:0], sda_s2};
            next_cnt = cnt + IMRC_CNT_ONE;
          end else if (scl_fall && cnt == IMRC_BYTE_BITS) begin
            // ack only our own address with a write flag
            if (shift[7:1] == own_addr &&
                shift[0] == IMRC_RW_WRITE) begin
              next_ack_oe = 1'h1;
              next_state = IMRC_AACK;
            end else begin
              next_state = IMRC_SKIP;
            end
          end
        end
        IMRC_AACK: begin
          // hold the ack low through one full clock pulse
          if (scl_fall) begin
            next_ack_oe = 1'h0;
            next_cnt = IMRC_CNT_ZERO;
            next_state = IMRC_DATA;
          end
        end
        IMRC_DATA: begin
          if (scl_rise) begin
            // data bits also sampled on the rising edge
            next_shift = {shift[6:0], sda_s2};
            next_cnt = cnt + IMRC_CNT_ONE;
          end else if (scl_fall && cnt == IMRC_BYTE_BITS) begin
            // keep the byte aside, not yet on the banks
            next_held = shift;
            next_held_ok = 1'h1;
            next_ack_oe = 1'h1;
            next_state = IMRC_DACK;
          end
        end
        IMRC_DACK: begin
          // after this ack every further byte is ignored
          if (scl_fall) begin
            next_ack_oe = 1'h0;
            next_state = IMRC_SKIP;
          end
        end
        IMRC_SKIP: begin
          // line left released, nothing shifted
          next_ack_oe = 1'h0;
        end
        default: begin
          // unknown code falls back to idle
          next_ack_oe = 1'h0;
          next_state = IMRC_IDLE;
        end
      endcase
    end
  end

  // registers of the serial slave; reset gives the default byte
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      state <= IMRC_IDLE;
      cnt <= IMRC_CNT_ZERO;
      shift <= 8'h00;
      held <= 8'h00;
      held_ok <= 1'h0;
      ctrl <= IMRC_CTRL_RESET;
      ack_oe <= 1'h0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      shift <= next_shift;
      held <= next_held;
      held_ok <= next_held_ok;
      ctrl <= next_ctrl;
      ack_oe <= next_ack_oe;
    end
  end

  // open-drain data: only ever pulls low
  assign sda_pin_out = 1'h0;
  assign sda_pin_oe = ack_oe;
  assign route_ctrl = ctrl;

  // bank inputs and outputs gathered for the routing loop
  imrc_bank_in_t bin [IMRC_BANKS];
  imrc_bank_out_t bout [IMRC_BANKS];
  logic [IMRC_BANKS-1:0] kind_bits;   // routing kind per bank
  logic [IMRC_BANKS-1:0] pick_bits;   // single pick per bank

  // bank order a, c, e, g from the byte's low pair upward
  assign kind_bits = {ctrl.bank_g_routing_kind,
                      ctrl.bank_e_routing_kind,
                      ctrl.bank_c_routing_kind,
                      ctrl.bank_a_routing_kind};
  assign pick_bits = {ctrl.bank_g_single_out_pick,
                      ctrl.bank_e_single_out_pick,
                      ctrl.bank_c_single_out_pick,
                      ctrl.bank_a_single_out_pick};

  assign bin[0] = {bank_a_in_zero, bank_a_in_one, bank_a_fanout_in};
  assign bin[1] = {bank_c_in_zero, bank_c_in_one, bank_c_fanout_in};
  assign bin[2] = {bank_e_in_zero, bank_e_in_one, bank_e_fanout_in};
  assign bin[3] = {bank_g_in_zero, bank_g_in_one, bank_g_fanout_in};

  // the data path stays combinational: these are fast signal switches,
  // and only their control comes from flops
  genvar b;
  generate
    for (b = 0; b < IMRC_BANKS; b++) begin : g_bank
      assign bout[b] = imrc_route(bin[b], kind_bits[b], pick_bits[b]);
    end
  endgenerate

  // bank outputs to their pins; limitation: a disabled single output reads
  // low here, so users must look at its enable, not at its value
  assign {bank_a_single_out, bank_a_single_out_oe,
          bank_a_pair_out_zero, bank_a_pair_out_one} = bout[0];
  assign {bank_c_single_out, bank_c_single_out_oe,
          bank_c_pair_out_zero, bank_c_pair_out_one} = bout[1];
  assign {bank_e_single_out, bank_e_single_out_oe,
          bank_e_pair_out_zero, bank_e_pair_out_one} = bout[2];
  assign {bank_g_single_out, bank_g_single_out_oe,
          bank_g_pair_out_zero, bank_g_pair_out_one} = bout[3];

endmodule

`default_nettype wire

// ==== verif/imrc_master.sv ====
// two-wire bus master model that writes to the route control block
// assumes a pull-up on the data wire; scl idles high between frames
`timescale 1ns/1ps
`default_nettype none
module imrc_master (
  input wire logic ref_clk, // pacing clock, moves on falling edge
  input wire logic sda_in, // resolved data wire level
  output logic scl, // serial clock, 800 ns period
  output logic sda_low // high while pulling data low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // a quarter of the serial period
  task automatic quarter();
    repeat (2) @(negedge ref_clk);
  endtask
  // data falls while the clock is high
  task automatic start();
    sda_low = 1'b1;
    quarter();
    scl = 1'b0;
    quarter();
  endtask
  // msb first, data moves only with the clock low; ninth bit is released
  task automatic put_byte(input logic [7:0] b, output logic ack);
    for (int i = 8; i >= 0; i--) begin
      sda_low = (i > 0) ? !b[i-1] : 1'b0;
      quarter();
      scl = 1'b1;
      quarter();
      if (i == 0) ack = !sda_in;
      quarter();
      scl = 1'b0;
      quarter();
    end
  endtask
  // data rises while the clock is high, then the bus idles
  task automatic stop();
    sda_low = 1'b1;
    quarter();
    scl = 1'b1;
    quarter();
    sda_low = 1'b0;
    repeat (4) quarter();
  endtask
endmodule
`default_nettype wire

// ==== verif/imrc_monitor.sv ====
// checker for the route control top: routing, ack and latch timing
// assumes it is bound onto imrc_top and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module imrc_monitor
  import imrc_pkg::*;
(
  input wire logic ref_clk, // block clock
  input wire logic resetn, // sync reset, low
  input wire logic scl_pin, // serial clock pin
  input wire logic sda_pin_out, // data drive value
  input wire logic sda_pin_oe, // data pull enable
  input wire imrc_ctrl_t route_ctrl, // latched control byte
  input wire logic bank_a_in_zero, // bank a input zero
  input wire logic bank_a_in_one, // bank a input one
  input wire logic bank_a_fanout_in, // bank a fan-out input
  input wire logic bank_a_single_out, // bank a single output
  input wire logic bank_a_single_out_oe, // bank a single enable
  input wire logic bank_a_pair_out_zero, // bank a pair zero
  input wire logic bank_a_pair_out_one, // bank a pair one
  input wire logic bank_c_single_out_oe, // bank c single enable
  input wire logic bank_e_single_out_oe, // bank e single enable
  input wire logic bank_g_single_out_oe // bank g single enable
);
  // one domain, so clock and reset are given once
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_reset_value: assert property (
    $rose(resetn) |-> route_ctrl == IMRC_CTRL_RESET)
    else $error("control byte not at power-up value");
  a_bank_a_mux: assert property (
    route_ctrl.bank_a_routing_kind |-> bank_a_single_out_oe &&
    bank_a_single_out == (route_ctrl.bank_a_single_out_pick ?
    bank_a_in_one : bank_a_in_zero))
    else $error("bank a single output wrong in mux routing");
  a_bank_a_fan: assert property (
    route_ctrl.bank_a_routing_kind |-> bank_a_pair_out_zero ==
    bank_a_fanout_in && bank_a_pair_out_one == bank_a_fanout_in)
    else $error("bank a pair outputs miss fan-out input");
  a_bank_a_straight: assert property (
    !route_ctrl.bank_a_routing_kind |-> !bank_a_single_out_oe &&
    bank_a_pair_out_zero == bank_a_in_one &&
    bank_a_pair_out_one == bank_a_in_zero)
    else $error("bank a straight routing wrong");
  a_bank_oe_kind: assert property (
    {bank_c_single_out_oe, bank_e_single_out_oe, bank_g_single_out_oe}
    == {route_ctrl.bank_c_routing_kind, route_ctrl.bank_e_routing_kind,
    route_ctrl.bank_g_routing_kind})
    else $error("single output enable does not follow kind");
  // a stop happens with the clock high, so any load must see it high
  a_latch_at_stop: assert property (
    $changed(route_ctrl) |-> scl_pin && $past(scl_pin, 3))
    else $error("control byte changed outside a stop");
  a_ack_stands: assert property (
    $rose(sda_pin_oe) |=> sda_pin_oe [*3] ##[1:12] !sda_pin_oe)
    else $error("ack pull length wrong");
  a_open_drain: assert property (
    sda_pin_out == 1'b0)
    else $error("data drive value not low");
endmodule
`default_nettype wire

// ==== verif/imrc_top_tb.sv ====
// self-checking bench for imrc_top with a bus master model
// assumes the checker is bound onto imrc_top below
`timescale 1ns/1ps
`default_nettype none
module imrc_top_tb
  import imrc_pkg::*;
;
  logic ref_clk = 1'b0; // 10 MHz block clock
  logic resetn = 1'b0; // sync reset, low
  logic addr_hi = 1'b0; // address pin, bit 2
  logic addr_lo = 1'b0; // address pin, bit 1
  logic [11:0] bi = 12'h000; // per bank {in_zero, in_one, fanout}
  logic [15:0] bo; // per bank {single, oe, pair0, pair1}
  logic scl, sda_low, sda_pin_out, sda_pin_oe, ack;
  wire sda_wire = !(sda_low || sda_pin_oe); // pulled up when released
  imrc_ctrl_t route_ctrl; // live control byte
  int errors = 0;
  int comparisons = 0;
  always #50 ref_clk = ~ref_clk;

  imrc_master imrc_master_i (.ref_clk(ref_clk), .sda_in(sda_wire),
    .scl(scl), .sda_low(sda_low));
  imrc_top imrc_top_i (.ref_clk(ref_clk), .resetn(resetn), .scl_pin(scl),
    .sda_pin_in(sda_wire), .sda_pin_out(sda_pin_out),
    .sda_pin_oe(sda_pin_oe), .slave_addr_pin_low(addr_lo),
    .slave_addr_pin_high(addr_hi), .bank_a_in_zero(bi[11]),
    .bank_a_in_one(bi[10]), .bank_a_fanout_in(bi[9]),
    .bank_c_in_zero(bi[8]), .bank_c_in_one(bi[7]), .bank_c_fanout_in(bi[6]),
    .bank_e_in_zero(bi[5]), .bank_e_in_one(bi[4]), .bank_e_fanout_in(bi[3]),
    .bank_g_in_zero(bi[2]), .bank_g_in_one(bi[1]), .bank_g_fanout_in(bi[0]),
    .bank_a_single_out(bo[15]), .bank_a_single_out_oe(bo[14]),
    .bank_a_pair_out_zero(bo[13]), .bank_a_pair_out_one(bo[12]),
    .bank_c_single_out(bo[11]), .bank_c_single_out_oe(bo[10]),
    .bank_c_pair_out_zero(bo[9]), .bank_c_pair_out_one(bo[8]),
    .bank_e_single_out(bo[7]), .bank_e_single_out_oe(bo[6]),
    .bank_e_pair_out_zero(bo[5]), .bank_e_pair_out_one(bo[4]),
    .bank_g_single_out(bo[3]), .bank_g_single_out_oe(bo[2]),
    .bank_g_pair_out_zero(bo[1]), .bank_g_pair_out_one(bo[0]),
    .route_ctrl(route_ctrl));

  task automatic chk(input string what, input logic [15:0] exp,
    input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    if (errors == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // expected {single, oe, pair0, pair1}; single reads 0 when high-z
  function automatic logic [3:0] exp_bank(logic k, logic p, logic [2:0] b);
    if (k) return {p ? b[1] : b[2], 1'b1, b[0], b[0]};
    return {1'b0, 1'b0, b[1], b[2]};
  endfunction
  // walks a one-hot input per bank, then one with only in_one low, so each route is seen apart
  task automatic check_banks(input imrc_ctrl_t c);
    logic [11:0] pat [4] = '{12'h924, 12'h492, 12'h249, 12'hb6d};
    logic [15:0] e;
    for (int k = 0; k < 4; k++) begin
      @(negedge ref_clk);
      bi = pat[k];
      @(posedge ref_clk);
      e = {exp_bank(c[1], c[0], bi[11:9]), exp_bank(c[3], c[2], bi[8:6]),
        exp_bank(c[5], c[4], bi[5:3]), exp_bank(c[7], c[6], bi[2:0])};
      chk("bank outputs", e, bo);
    end
  endtask
  // whole transfer; the old byte must hold until the stop
  task automatic frame(input logic [7:0] adr, input logic [7:0] d,
    input logic want);
    imrc_ctrl_t old;
    old = route_ctrl;
    imrc_master_i.start();
    imrc_master_i.put_byte(adr, ack);
    chk("address ack", {15'h0, want}, {15'h0, ack});
    imrc_master_i.put_byte(d, ack);
    chk("data ack", {15'h0, want}, {15'h0, ack});
    chk("held byte", {8'h00, old}, {8'h00, route_ctrl});
    imrc_master_i.stop();
  endtask

  task automatic t_power_up();
    chk("route_ctrl", {8'h00, IMRC_CTRL_RESET}, {8'h00, route_ctrl});
    check_banks(IMRC_CTRL_RESET);
  endtask
  task automatic t_addresses();
    logic [7:0] dat [4] = '{8'h55, 8'hff, 8'h00, 8'h2e};
    for (int p = 0; p < 4; p++) begin
      @(negedge ref_clk);
      {addr_hi, addr_lo} = p[1:0];
      frame({IMRC_ADDR_PREFIX, p[1:0], IMRC_RW_WRITE}, dat[p], 1'b1);
      chk("route_ctrl", {8'h00, dat[p]}, {8'h00, route_ctrl});
      check_banks(dat[p]);
    end
  endtask
  task automatic t_refused();
    @(negedge ref_clk);
    {addr_hi, addr_lo} = 2'h0;
    frame({IMRC_ADDR_PREFIX, 2'h3, IMRC_RW_WRITE}, 8'h5a, 1'b0);
    frame({5'h1a, 2'h0, IMRC_RW_WRITE}, 8'h5a, 1'b0);
    frame({IMRC_ADDR_PREFIX, 2'h0, 1'b1}, 8'h5a, 1'b0);
    chk("route_ctrl", 16'h002e, {8'h00, route_ctrl});
  endtask
  task automatic t_extra();
    imrc_master_i.start();
    imrc_master_i.put_byte({IMRC_ADDR_PREFIX, 2'h0, IMRC_RW_WRITE}, ack);
    imrc_master_i.put_byte(8'h99, ack);
    chk("first data ack", 16'h0001, {15'h0, ack});
    imrc_master_i.put_byte(8'h66, ack);
    chk("extra byte ack", 16'h0000, {15'h0, ack});
    imrc_master_i.stop();
    chk("route_ctrl", 16'h0099, {8'h00, route_ctrl});
  endtask
  // a stop right after the address ack carries no byte, so nothing loads
  task automatic t_cut();
    imrc_master_i.start();
    imrc_master_i.put_byte({IMRC_ADDR_PREFIX, 2'h0, IMRC_RW_WRITE}, ack);
    chk("cut address ack", 16'h0001, {15'h0, ack});
    imrc_master_i.stop();
    chk("cut route_ctrl", 16'h0099, {8'h00, route_ctrl});
  endtask

  initial begin
    repeat (3) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (3) @(negedge ref_clk);
    t_power_up();
    t_addresses();
    t_refused();
    t_extra();
    t_cut();
    end_sim();
  end
  // run needs about 1,500 cycles; allow over six times that
  initial begin
    #1000000;
    errors++;
    end_sim();
  end
endmodule
bind imrc_top imrc_monitor imrc_monitor_i (.ref_clk, .resetn, .scl_pin,
  .sda_pin_out, .sda_pin_oe, .route_ctrl, .bank_a_in_zero, .bank_a_in_one,
  .bank_a_fanout_in, .bank_a_single_out, .bank_a_single_out_oe,
  .bank_a_pair_out_zero, .bank_a_pair_out_one, .bank_c_single_out_oe,
  .bank_e_single_out_oe, .bank_g_single_out_oe);
`default_nettype wire
